// file: rtl/aco_pkg.sv
// package: opcodes, register map, flag positions and field layouts
package aco_pkg;
    // 12-bit instruction encodings (opcode fields)
    localparam logic [11:0] OP_NIBBLE_EXCHANGE = 12'h380; // 0011 10df ffff
    localparam logic [11:0] OP_XOR_ACC_FILE = 12'h180;    // 0001 10df ffff
    localparam logic [11:0] OP_SUBTRACT = 12'h080;        // 0000 10df ffff
    localparam logic [11:0] OP_ROTATE_RIGHT = 12'h300;    // 0011 00df ffff
    localparam logic [11:0] OP_ROTATE_LEFT = 12'h340;     // 0011 01df ffff
    localparam logic [11:0] OP_RETURN_LIT = 12'h800;      // 1000 kkkk kkkk
    localparam logic [11:0] OP_XOR_LIT = 12'hF00;         // 1111 kkkk kkkk
    localparam logic [11:0] OP_HALT = 12'h003;
    localparam logic [11:0] OP_DIR_LOAD = 12'h000;        // 0000 0000 0fff
    localparam logic [11:0] MASK_FILE_OP = 12'hFC0;
    localparam logic [11:0] MASK_LIT_OP = 12'hF00;
    localparam logic [11:0] MASK_DIR_OP = 12'hFF8;
    localparam logic [2:0] DIR_SEL_LO = 3'h6;
    localparam logic [2:0] DIR_SEL_HI = 3'h7;
    localparam int DEST_BIT = 5;
    localparam int FADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int INSN_W = 12;
    localparam int PC_W = 9;
    // status flag positions
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_HALF = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_PDOWN = 3;
    localparam int FLAG_TOUT = 4;
    localparam int FLAG_WAKE = 7;
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] WDT_CLEAR = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [1:0] RETURN_CYCLES = 2'h2;
    // AXI4-Lite register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;    // w: instruction; r: core state
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_FSEL = 8'h0C;    // file address for window
    localparam logic [7:0] REG_FDATA = 8'h10;   // file data at REG_FSEL
    localparam logic [7:0] REG_STACK = 8'h14;   // stack top entry
    localparam logic [7:0] REG_PC = 8'h18;
    localparam logic [7:0] REG_DIR6 = 8'h1C;
    localparam logic [7:0] REG_DIR7 = 8'h20;
    localparam logic [7:0] REG_SYS = 8'h24;     // wdt in bits 7:0, prescaler in bits 15:8
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rtl/aco_core.sv
// execution unit for rotate, subtract, swap, xor, return and halt ops
`timescale 1ns/10ps
// How it works
// - return loads literal into acc, flags kept
// - return pops stack top, two cycles
// - halt zeroes watchdog counter and prescaler
// - halt sets timeout, clears powerdown, wake kept
// - halt then enters sleep, oscillator stopped
// - rotates through carry, only carry changes
// - file address 0..31, dest bit picks target
// - subtract file minus acc, sets C DC Z
// - swap exchanges nibbles, no flags change
// - direction load copies acc to reg 6/7
// - xor literal into acc, zero flag updated
// - xor file into destination, zero updated
module aco_core
    import aco_pkg::*;
#(
    parameter int NFILE = 32
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic i_wake,
    output logic o_sleep,
    output logic o_osc_run
);

    typedef enum logic [1:0] {
        ACO_IDLE = 2'b00,
        ACO_POP = 2'b01,
        ACO_SLEEP = 2'b10
    } aco_state_e;

    typedef struct packed {
        aco_state_e st;
        logic [DATA_W-1:0] acc;
        logic [DATA_W-1:0] status;
        logic [NFILE-1:0][DATA_W-1:0] file;
        logic [PC_W-1:0] stack_top;
        logic [PC_W-1:0] pc;
        logic [DATA_W-1:0] dir6;
        logic [DATA_W-1:0] dir7;
        logic [DATA_W-1:0] wdt;
        logic [DATA_W-1:0] presc;
        logic [FADDR_W-1:0] fsel;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic wake_m;
        logic wake_s;
        logic awready;
        logic wready;
        logic arready;
        logic sleep;
        logic osc_run;
    } aco_regs_s;

    aco_regs_s r;
    aco_regs_s next_r;

    // zero test shared by every op that touches the zero flag
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return (v == '0);
    endfunction

    // widen an 8-bit field into a bus word
    function automatic logic [31:0] word8(input logic [DATA_W-1:0] v);
        return {24'h000000, v};
    endfunction

    logic [INSN_W-1:0] insn;
    logic [FADDR_W-1:0] fa;
    logic [DATA_W-1:0] fv;
    logic [DATA_W-1:0] res;
    logic [DATA_W:0] diff;
    logic [4:0] hdiff;
    logic to_file;
    logic wr_fire;
    logic busy;

    // ------------------------------------------------------------
    // combined next-state: bus slave plus instruction execution
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        insn = r.w_data[INSN_W-1:0];
        fa = insn[FADDR_W-1:0];
        fv = r.file[fa];
        res = '0;
        to_file = insn[DEST_BIT];
        diff = {1'b0, fv} - {1'b0, r.acc};
        hdiff = {1'b0, fv[3:0]} - {1'b0, r.acc[3:0]};
        busy = (r.st != ACO_IDLE);
        wr_fire = 1'b0;
        // synchronised wake level
        next_r.wake_m = i_wake;
        next_r.wake_s = r.wake_m;
        // watchdog counter with prescaler, counting except while asleep
        next_r.presc = r.presc + 8'h01;
        if (r.presc == 8'hFF) begin
            next_r.wdt = r.wdt + 8'h01;
        end
        // write address and data channels taken in either order
        if (i_s_axi_awvalid && !r.aw_hold && !r.bvalid) begin
            next_r.aw_hold = 1'b1;
            next_r.aw_addr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && !r.w_hold && !r.bvalid) begin
            next_r.w_hold = 1'b1;
            next_r.w_data = i_s_axi_wdata;
            next_r.w_strb = i_s_axi_wstrb;
        end
        if (r.aw_hold && r.w_hold) begin
            wr_fire = 1'b1;
            next_r.aw_hold = 1'b0;
            next_r.w_hold = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = RESP_OKAY;
        end
        if (r.bvalid && i_s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        // register writes; an instruction write is refused while busy
        if (wr_fire) begin
            case (r.aw_addr)
                REG_CTRL: begin
                    if (busy) begin
                        next_r.bresp = RESP_SLVERR;
                    end else if ((insn & MASK_LIT_OP) == OP_RETURN_LIT) begin
                        next_r.acc = insn[DATA_W-1:0];
                        next_r.st = ACO_POP;
                    end else if ((insn & MASK_LIT_OP) == OP_XOR_LIT) begin
                        res = r.acc ^ insn[DATA_W-1:0];
                        next_r.acc = res;
                        next_r.status[FLAG_ZERO] = is_zero(res);
                    end else if (insn == OP_HALT) begin
                        next_r.wdt = WDT_CLEAR;
                        next_r.presc = WDT_CLEAR;
                        next_r.status[FLAG_TOUT] = 1'b1;
                        next_r.status[FLAG_PDOWN] = 1'b0;
                        next_r.st = ACO_SLEEP;
                    end else if ((insn & MASK_DIR_OP) == OP_DIR_LOAD) begin
                        if (insn[2:0] == DIR_SEL_LO) begin
                            next_r.dir6 = r.acc;
                        end else if (insn[2:0] == DIR_SEL_HI) begin
                            next_r.dir7 = r.acc;
                        end else begin
                            next_r.bresp = RESP_SLVERR;
                        end
                    end else begin
                        case (insn & MASK_FILE_OP)
                            OP_ROTATE_LEFT: begin
                                res = {fv[6:0], r.status[FLAG_CARRY]};
                                next_r.status[FLAG_CARRY] = fv[7];
                            end
                            OP_ROTATE_RIGHT: begin
                                res = {r.status[FLAG_CARRY], fv[7:1]};
                                next_r.status[FLAG_CARRY] = fv[0];
                            end
                            OP_SUBTRACT: begin
                                res = diff[DATA_W-1:0];
                                next_r.status[FLAG_CARRY] = ~diff[DATA_W];
                                next_r.status[FLAG_HALF] = ~hdiff[4];
                                next_r.status[FLAG_ZERO] = is_zero(res);
                            end
                            OP_NIBBLE_EXCHANGE: begin
                                res = {fv[3:0], fv[7:4]};
                            end
                            OP_XOR_ACC_FILE: begin
                                res = r.acc ^ fv;
                                next_r.status[FLAG_ZERO] = is_zero(res);
                            end
                            default: begin
                                to_file = 1'b0;
                                res = r.acc;
                                next_r.bresp = RESP_SLVERR;
                            end
                        endcase
                        if (to_file) begin
                            next_r.file[fa] = res;
                        end else begin
                            next_r.acc = res;
                        end
                    end
                end
                REG_ACC: next_r.acc = r.w_data[DATA_W-1:0];
                REG_STATUS: next_r.status = r.w_data[DATA_W-1:0];
                REG_FSEL: next_r.fsel = r.w_data[FADDR_W-1:0];
                REG_FDATA: next_r.file[r.fsel] = r.w_data[DATA_W-1:0];
                REG_STACK: next_r.stack_top = r.w_data[PC_W-1:0];
                REG_PC: next_r.pc = r.w_data[PC_W-1:0];
                default: next_r.bresp = RESP_SLVERR;
            endcase
        end
        // second cycle of return: stack top into program counter
        if (r.st == ACO_POP) begin
            next_r.pc = r.stack_top;
            next_r.st = ACO_IDLE;
        end
        // sleep: watchdog frozen with the oscillator until a wake
        if (r.st == ACO_SLEEP) begin
            next_r.wdt = r.wdt;
            next_r.presc = r.presc;
            if (r.wake_s) begin
                next_r.st = ACO_IDLE;
            end
        end
        // read channel
        if (i_s_axi_arvalid && !r.rvalid) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = RESP_OKAY;
            case (i_s_axi_araddr)
                REG_CTRL: next_r.rdata = {30'h00000000, r.st};
                REG_ACC: next_r.rdata = word8(r.acc);
                REG_STATUS: next_r.rdata = word8(r.status);
                REG_FSEL: next_r.rdata = {27'h0000000, r.fsel};
                REG_FDATA: next_r.rdata = word8(r.file[r.fsel]);
                REG_STACK: next_r.rdata = {23'h000000, r.stack_top};
                REG_PC: next_r.rdata = {23'h000000, r.pc};
                REG_DIR6: next_r.rdata = word8(r.dir6);
                REG_DIR7: next_r.rdata = word8(r.dir7);
                REG_SYS: next_r.rdata = {16'h0000, r.presc, r.wdt};
                default: begin
                    next_r.rdata = '0;
                    next_r.rresp = RESP_SLVERR;
                end
            endcase
        end else if (r.rvalid && i_s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        // readies and sleep pins registered from their next values
        next_r.awready = !next_r.aw_hold && !next_r.bvalid;
        next_r.wready = !next_r.w_hold && !next_r.bvalid;
        next_r.arready = !next_r.rvalid;
        next_r.sleep = (next_r.st == ACO_SLEEP);
        next_r.osc_run = (next_r.st != ACO_SLEEP);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r <= '0;
            r.status <= STATUS_RST;
            r.dir6 <= DIR_RST;
            r.dir7 <= DIR_RST;
            r.awready <= 1'b1;
            r.wready <= 1'b1;
            r.arready <= 1'b1;
            r.osc_run <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flip-flops
    assign o_s_axi_awready = r.awready;
    assign o_s_axi_wready = r.wready;
    assign o_s_axi_bvalid = r.bvalid;
    assign o_s_axi_bresp = r.bresp;
    assign o_s_axi_arready = r.arready;
    assign o_s_axi_rvalid = r.rvalid;
    assign o_s_axi_rdata = r.rdata;
    assign o_s_axi_rresp = r.rresp;
    assign o_sleep = r.sleep;
    assign o_osc_run = r.osc_run;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    ret_two_cycle_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (r.st == ACO_POP) |=> (r.pc == $past(r.stack_top)) && (r.st == ACO_IDLE))
        else $error("return did not load pc from stack top");
    ret_flags_kept_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        $rose(r.st == ACO_POP) |-> r.status == $past(r.status))
        else $error("return changed status");
    halt_wdt_clr_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        $rose(r.st == ACO_SLEEP) |-> r.wdt == WDT_CLEAR && r.presc == WDT_CLEAR)
        else $error("halt left watchdog running");
    halt_flags_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        $rose(r.st == ACO_SLEEP) |-> r.status[FLAG_TOUT] && !r.status[FLAG_PDOWN]
            && r.status[FLAG_WAKE] == $past(r.status[FLAG_WAKE]))
        else $error("halt flag update wrong");
    sleep_osc_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (r.st == ACO_SLEEP && !r.wake_s) |=> o_sleep && !o_osc_run)
        else $error("sleep left oscillator running");
    zero_flag_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (wr_fire && r.aw_addr == REG_CTRL && !busy
            && (insn & MASK_LIT_OP) == OP_XOR_LIT)
        |=> r.status[FLAG_ZERO] == (r.acc == 8'h00))
        else $error("zero flag disagrees with result");
    swap_flags_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (wr_fire && r.aw_addr == REG_CTRL && !busy
            && (insn & MASK_FILE_OP) == OP_NIBBLE_EXCHANGE)
        |=> $stable(r.status))
        else $error("swap altered status");
    dir_load_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (wr_fire && r.aw_addr == REG_CTRL && !busy
            && insn == (OP_DIR_LOAD | 12'h006))
        |=> r.dir6 == $past(r.acc) && $stable(r.status))
        else $error("direction load failed");
    rot_carry_only_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (wr_fire && r.aw_addr == REG_CTRL && !busy
            && ((insn & MASK_FILE_OP) == OP_ROTATE_LEFT
            || (insn & MASK_FILE_OP) == OP_ROTATE_RIGHT))
        |=> r.status[DATA_W-1:FLAG_HALF] == $past(r.status[DATA_W-1:FLAG_HALF]))
        else $error("rotate changed a flag other than carry");
    sub_carry_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (wr_fire && r.aw_addr == REG_CTRL && !busy
            && (insn & MASK_FILE_OP) == OP_SUBTRACT)
        |=> r.status[FLAG_CARRY] == ($past(fv) >= $past(r.acc)))
        else $error("subtract carry disagrees with borrow");

endmodule // aco_core

// file: test/tb_accumulator_alu_and_control_ops.sv
// testbench for the accumulator alu and control operations block
`timescale 1ns/10ps
module tb_accumulator_alu_and_control_ops
    import aco_pkg::*;
;
    // ---------------------------------------------------------------
    // stimulus signals and design
    // ---------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic wake = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sleep, osc_run;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, base, v;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    // clock at 40 MHz
    always #12.5 clk = ~clk;

    // response channels always ready, all strobes on
    aco_core #(.NFILE(32)) DUT (
        .i_core_clk(clk), .i_rst_b(rst_b),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(1'b1),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(1'b1), .i_wake(wake), .o_sleep(sleep),
        .o_osc_run(osc_run)
    );

    // cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end

    // ---------------------------------------------------------------
    // bus and compare tasks
    // ---------------------------------------------------------------
    task automatic end_sim();
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] rr);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rr = rresp;
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        rd(a, v, r);
        chk(v, e);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    task automatic exec(input logic [11:0] op, input logic [1:0] er);
        wr(REG_CTRL, {20'h0, op}, er);
    endtask

    task automatic setf(input logic [4:0] f, input logic [7:0] d);
        wr(REG_FSEL, {27'h0, f}, RESP_OKAY);
        wr(REG_FDATA, {24'h0, d}, RESP_OKAY);
    endtask

    task automatic chkf(input logic [4:0] f, input logic [7:0] e);
        wr(REG_FSEL, {27'h0, f}, RESP_OKAY);
        expect_reg(REG_FDATA, {24'h0, e});
    endtask

    // status baseline, then compare with new low three flags
    task automatic clr_st(input logic [7:0] s);
        wr(REG_STATUS, {24'h0, s}, RESP_OKAY);
        base = {24'h0, s};
        expect_reg(REG_STATUS, base);
    endtask

    task automatic chk_st(input logic [2:0] f);
        expect_reg(REG_STATUS, {base[31:3], f});
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_sub();
        clr_st(8'h00);
        wr(REG_ACC, 32'h05, RESP_OKAY);
        setf(5'h03, 8'h05);
        exec(OP_SUBTRACT | 12'h023, RESP_OKAY);
        chkf(5'h03, 8'h00);
        chk_st(3'b111);
        setf(5'h03, 8'h13);
        exec(OP_SUBTRACT | 12'h003, RESP_OKAY);
        expect_reg(REG_ACC, 32'h0E);
        chk_st(3'b001);
        setf(5'h03, 8'h03);
        exec(OP_SUBTRACT | 12'h003, RESP_OKAY);
        expect_reg(REG_ACC, 32'hF5);
        chk_st(3'b000);
        chkf(5'h03, 8'h03);
    endtask

    task automatic t_rot_swap();
        clr_st(8'h06);
        setf(5'h07, 8'h81);
        exec(OP_ROTATE_LEFT | 12'h027, RESP_OKAY);
        chkf(5'h07, 8'h02);
        chk_st(3'b111);
        exec(OP_ROTATE_RIGHT | 12'h007, RESP_OKAY);
        expect_reg(REG_ACC, 32'h81);
        chk_st(3'b110);
        clr_st(8'h07);
        setf(5'h1F, 8'hA5);
        exec(OP_NIBBLE_EXCHANGE | 12'h01F, RESP_OKAY);
        expect_reg(REG_ACC, 32'h5A);
        exec(OP_NIBBLE_EXCHANGE | 12'h03F, RESP_OKAY);
        chkf(5'h1F, 8'h5A);
        chk_st(3'b111);
    endtask

    task automatic t_xor();
        clr_st(8'h00);
        wr(REG_ACC, 32'h3C, RESP_OKAY);
        exec(OP_XOR_LIT | 12'h03C, RESP_OKAY);
        expect_reg(REG_ACC, 32'h00);
        chk_st(3'b100);
        exec(OP_XOR_LIT | 12'h0FF, RESP_OKAY);
        chk_st(3'b000);
        setf(5'h02, 8'h0F);
        exec(OP_XOR_ACC_FILE | 12'h022, RESP_OKAY);
        chkf(5'h02, 8'hF0);
        expect_reg(REG_ACC, 32'hFF);
        wr(REG_ACC, 32'hF0, RESP_OKAY);
        exec(OP_XOR_ACC_FILE | 12'h022, RESP_OKAY);
        chkf(5'h02, 8'h00);
        chk_st(3'b100);
    endtask

    task automatic t_dir_ret();
        clr_st(8'h07);
        wr(REG_ACC, 32'h3A, RESP_OKAY);
        exec(OP_DIR_LOAD | 12'h006, RESP_OKAY);
        wr(REG_ACC, 32'h15, RESP_OKAY);
        exec(OP_DIR_LOAD | 12'h007, RESP_OKAY);
        exec(OP_DIR_LOAD | 12'h005, RESP_SLVERR);
        expect_reg(REG_DIR6, 32'h3A);
        expect_reg(REG_DIR7, 32'h15);
        chk_st(3'b111);
        clr_st(8'h05);
        wr(REG_STACK, 32'h123, RESP_OKAY);
        exec(OP_RETURN_LIT | 12'h0C3, RESP_OKAY);
        expect_reg(REG_ACC, 32'hC3);
        expect_reg(REG_PC, 32'h123);
        chk_st(3'b101);
    endtask

    task automatic t_halt();
        int n;
        clr_st(8'h80);
        exec(OP_HALT, RESP_OKAY);
        @(posedge clk);
        chk({30'h0, sleep, osc_run}, 32'h2);
        expect_reg(REG_STATUS, (base | 32'h10) & ~32'h08);
        expect_reg(REG_CTRL, 32'h2);
        rd(REG_SYS, v, r);
        chk(v & 32'hFFFF, 32'h0);
        exec(OP_XOR_LIT, RESP_SLVERR);
        wake <= 1'b1;
        n = 0;
        while (sleep && n < 20) begin
            @(posedge clk);
            n++;
        end
        wake <= 1'b0;
        chk({31'h0, osc_run}, 32'h1);
        expect_reg(REG_CTRL, 32'h0);
        rd(8'h40, v, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h44, 32'h0, RESP_SLVERR);
    endtask

    // reset for ten cycles, then every scenario in turn
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        expect_reg(REG_STATUS, {24'h0, STATUS_RST});
        expect_reg(REG_DIR6, {24'h0, DIR_RST});
        t_sub();
        t_rot_swap();
        t_xor();
        t_dir_ret();
        t_halt();
        end_sim();
    end
endmodule // tb_accumulator_alu_and_control_ops
